// [switch_port_ingress_control_regs.v]
// port control register bank with avalon-mm slave and per-port control outputs
// assumes one clock domain, a master that holds requests until waitrequest low,
// and a datapath that consumes the decoded per-port control levels
`include "switch_port_ingress_control_regs.vh"

// Functional notes
// - five-bit port 1 phy address in bits 7..3, legal 1..29, resets to 1
// - port 2 phy address is port 1 phy address plus one
// - each port has identical control 0 and control 1 at 0x10/0x20/0x30 and next
// - control 0 bit 7 enables broadcast storm protection on ingress
// - control 0 bit 6 enables diffserv classification of ipv4 ingress packets
// - control 0 bit 5 enables 802.1p tag priority classification
// - control 0 bits 4..3 give fallback port priority queue, reset 00
// - 802.1p and dscp results or together and override port priority
// - control 0 bit 2 inserts default vid tag on untagged egress packets
// - control 0 bit 1 strips tags from tagged egress packets
// - control 0 bit 0 splits transmit queue into four queues
// - control 1 bit 7 makes the port the sniffer port
// - 802.1p values map to two-bit priority through global mapping fields
// - receive and transmit sniff bits mark port packets as monitored
module switch_port_ingress_control_regs #(
    parameter NUM_PORTS = 3
) (
    input  wire                   clk_i,
    input  wire                   reset_i,
    // avalon-mm slave
    input  wire [9:0]             avs_address_i,
    input  wire                   avs_read_i,
    input  wire                   avs_write_i,
    input  wire [31:0]            avs_writedata_i,
    input  wire [3:0]             avs_byteenable_i,
    output wire [31:0]            avs_readdata_o,
    output wire                   avs_waitrequest_o,
    output wire [1:0]             avs_response_o,
    // phy management addresses
    output wire [4:0]             port1_phy_addr_o,
    output wire [4:0]             port2_phy_addr_o,
    // per-port decoded controls, bit n is port n+1
    output wire [NUM_PORTS-1:0]   storm_protect_en_o,
    output wire [NUM_PORTS-1:0]   diffserv_en_o,
    output wire [NUM_PORTS-1:0]   dot1p_en_o,
    output wire [NUM_PORTS-1:0]   tag_insert_en_o,
    output wire [NUM_PORTS-1:0]   tag_remove_en_o,
    output wire [NUM_PORTS-1:0]   tx_queue_four_split_enable_o,
    output wire [NUM_PORTS-1:0]   sniffer_port_o,
    output wire [NUM_PORTS-1:0]   rx_monitor_o,
    output wire [NUM_PORTS-1:0]   tx_monitor_o,
    // ingress classification request for a frame on port frame_port_i
    input  wire [1:0]             frame_port_i,
    input  wire                   frame_tagged_i,
    input  wire [2:0]             frame_tag_prio_i,
    input  wire                   frame_ipv4_i,
    input  wire [1:0]             frame_dscp_prio_i,
    output wire [1:0]             frame_prio_o,
    // egress tag decision for a frame leaving port egress_port_i
    input  wire [1:0]             egress_port_i,
    input  wire                   egress_was_tagged_i,
    output wire                   egress_add_tag_o,
    output wire                   egress_strip_tag_o,
    // monitor decision for a frame between rx and tx ports
    input  wire [1:0]             mon_rx_port_i,
    input  wire [1:0]             mon_tx_port_i,
    output wire                   mon_forward_o
);
    // =========================================================
    // functions
    // =========================================================
    // port number 1..3 to index, 0 for out-of-range
    function [1:0] port_index;
        input [1:0] port;
        begin
            if (port == 2'h0) begin
                port_index = 2'h0;
            end else begin
                port_index = port - 2'h1;
            end
        end
    endfunction

    function port_valid;
        input [1:0] port;
        begin
            port_valid = (port != 2'h0) && ({30'h0, port} <= NUM_PORTS);
        end
    endfunction

    // =========================================================
    // register storage
    // =========================================================
    reg [4:0]  phy_addr_ff;
    reg [7:0]  tag_map_lo_ff;
    reg [7:0]  tag_map_hi_ff;
    reg [7:0]  ingress_ff [0:NUM_PORTS-1];
    reg [7:0]  monitor_ff [0:NUM_PORTS-1];
    reg        ack_ff;
    reg [31:0] rdata_ff;
    reg        resp_err_ff;

    // =========================================================
    // address decode
    // =========================================================
    wire [7:0] reg_idx;
    wire       access;
    wire       wr_lane0;
    reg  [7:0] nxt_rdata;
    reg        nxt_hit;

    assign reg_idx  = avs_address_i[9:2];
    assign access   = (avs_read_i | avs_write_i) & ~ack_ff;
    assign wr_lane0 = avs_write_i & avs_byteenable_i[0] & access;

    integer k;
    always @* begin
        nxt_rdata = 8'h00;
        nxt_hit   = 1'b1;
        case (reg_idx)
            `PHY_ADDR_IDX: begin
                nxt_rdata = {phy_addr_ff, `PHY_RSVD_RST};
            end
            `TAG_MAP_LO_IDX: begin
                nxt_rdata = tag_map_lo_ff;
            end
            `TAG_MAP_HI_IDX: begin
                nxt_rdata = tag_map_hi_ff;
            end
            `PORT1_INGRESS_IDX, `PORT2_INGRESS_IDX, `PORT3_INGRESS_IDX: begin
                nxt_rdata = ingress_ff[reg_idx[5:4] - 2'h1];
            end
            `PORT1_MONITOR_IDX, `PORT2_MONITOR_IDX, `PORT3_MONITOR_IDX: begin
                nxt_rdata = monitor_ff[reg_idx[5:4] - 2'h1];
            end
            default: begin
                nxt_hit = 1'b0;
            end
        endcase
        if (nxt_hit && reg_idx[5:4] != 2'h0 && reg_idx[7:4] != 4'h0 && {28'h0, reg_idx[7:4]} > NUM_PORTS) begin
            nxt_hit   = 1'b0;
            nxt_rdata = 8'h00;
        end
    end

    // =========================================================
    // bus handshake: one wait cycle, answer on the second
    // =========================================================
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_ff      <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            resp_err_ff <= 1'b0;
        end else begin
            ack_ff      <= access;
            resp_err_ff <= access & ~nxt_hit;
            if (access && avs_read_i) begin
                rdata_ff <= {24'h00_0000, nxt_rdata};
            end
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
    assign avs_readdata_o    = rdata_ff;
    assign avs_response_o    = resp_err_ff ? 2'h2 : 2'h0;

    // =========================================================
    // register writes
    // =========================================================
    wire [4:0] wr_phy;
    assign wr_phy = avs_writedata_i[`PHY_ADDR_MSB:`PHY_ADDR_LSB];

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phy_addr_ff   <= `PHY_ADDR_RST;
            tag_map_lo_ff <= `TAG_MAP_LO_RST;
            tag_map_hi_ff <= `TAG_MAP_HI_RST;
            for (k = 0; k < NUM_PORTS; k = k + 1) begin
                ingress_ff[k] <= `ING_RST;
                monitor_ff[k] <= `MON_RST;
            end
        end else if (wr_lane0 && nxt_hit) begin
            case (reg_idx)
                `PHY_ADDR_IDX: begin
                    // non-applicable codes are ignored, keeping a usable address
                    if (wr_phy != 5'h00 && wr_phy <= `PHY_ADDR_MAX) begin
                        phy_addr_ff <= wr_phy;
                    end
                end
                `TAG_MAP_LO_IDX: begin
                    tag_map_lo_ff <= avs_writedata_i[7:0];
                end
                `TAG_MAP_HI_IDX: begin
                    tag_map_hi_ff <= avs_writedata_i[7:0];
                end
                `PORT1_INGRESS_IDX, `PORT2_INGRESS_IDX, `PORT3_INGRESS_IDX: begin
                    ingress_ff[reg_idx[5:4] - 2'h1] <= avs_writedata_i[7:0];
                end
                `PORT1_MONITOR_IDX, `PORT2_MONITOR_IDX, `PORT3_MONITOR_IDX: begin
                    monitor_ff[reg_idx[5:4] - 2'h1] <= avs_writedata_i[7:0];
                end
                default: begin
                    phy_addr_ff <= phy_addr_ff;
                end
            endcase
        end
    end

    // =========================================================
    // decoded control levels
    // =========================================================
    assign port1_phy_addr_o = phy_addr_ff;
    assign port2_phy_addr_o = phy_addr_ff + 5'h01;

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g = g + 1) begin : port_ctl
            assign storm_protect_en_o[g]           = ingress_ff[g][`ING_STORM_BIT];
            assign diffserv_en_o[g]                = ingress_ff[g][`ING_DIFFSERV_BIT];
            assign dot1p_en_o[g]                   = ingress_ff[g][`ING_DOT1P_BIT];
            assign tag_insert_en_o[g]              = ingress_ff[g][`ING_TAG_INSERT_BIT];
            assign tag_remove_en_o[g]              = ingress_ff[g][`ING_TAG_REMOVE_BIT];
            assign tx_queue_four_split_enable_o[g] = ingress_ff[g][`ING_TXQ_SPLIT_BIT];
            assign sniffer_port_o[g]               = monitor_ff[g][`MON_SNIFFER_BIT];
            assign rx_monitor_o[g]                 = monitor_ff[g][`MON_RX_SNIFF_BIT];
            assign tx_monitor_o[g]                 = monitor_ff[g][`MON_TX_SNIFF_BIT];
        end
    endgenerate

    // =========================================================
    // ingress classification
    // =========================================================
    wire [1:0] in_idx;
    wire       in_ok;
    wire [7:0] in_ctl;
    assign in_idx = port_index(frame_port_i);
    assign in_ok  = port_valid(frame_port_i);
    assign in_ctl = in_ok ? ingress_ff[in_idx] : `ING_RST;

    prio_classifier classifier (
        .diffserv_en_i     (in_ctl[`ING_DIFFSERV_BIT]),
        .dot1p_en_i        (in_ctl[`ING_DOT1P_BIT]),
        .port_prio_i       (in_ctl[`ING_PORT_PRIO_MSB:`ING_PORT_PRIO_LSB]),
        .tag_map_i         ({tag_map_hi_ff, tag_map_lo_ff}),
        .frame_tagged_i    (frame_tagged_i),
        .frame_tag_prio_i  (frame_tag_prio_i),
        .frame_ipv4_i      (frame_ipv4_i),
        .frame_dscp_prio_i (frame_dscp_prio_i),
        .prio_o            (frame_prio_o)
    );

    // =========================================================
    // egress tagging and monitoring
    // =========================================================
    wire [1:0] eg_idx;
    wire       eg_ok;
    wire [1:0] mrx_idx;
    wire [1:0] mtx_idx;
    assign eg_idx  = port_index(egress_port_i);
    assign eg_ok   = port_valid(egress_port_i);
    assign mrx_idx = port_index(mon_rx_port_i);
    assign mtx_idx = port_index(mon_tx_port_i);

    // tagged frames never get a second tag
    assign egress_add_tag_o   = eg_ok & ingress_ff[eg_idx][`ING_TAG_INSERT_BIT] & ~egress_was_tagged_i;
    assign egress_strip_tag_o = eg_ok & ingress_ff[eg_idx][`ING_TAG_REMOVE_BIT] & egress_was_tagged_i;
    assign mon_forward_o      = (port_valid(mon_rx_port_i) & monitor_ff[mrx_idx][`MON_RX_SNIFF_BIT])
                              | (port_valid(mon_tx_port_i) & monitor_ff[mtx_idx][`MON_TX_SNIFF_BIT]);
endmodule

// [switch_port_ingress_control_regs.vh]
// register offsets, field positions and reset values of the port control bank
// assumes inclusion by bare name from the design files
`ifndef SWITCH_PORT_INGRESS_CONTROL_REGS_VH
`define SWITCH_PORT_INGRESS_CONTROL_REGS_VH

// printed register indices; byte address is four times the index
`define PHY_ADDR_IDX          8'h0F
`define PORT1_INGRESS_IDX     8'h10
`define PORT1_MONITOR_IDX     8'h11
`define PORT2_INGRESS_IDX     8'h20
`define PORT2_MONITOR_IDX     8'h21
`define PORT3_INGRESS_IDX     8'h30
`define PORT3_MONITOR_IDX     8'h31
`define TAG_MAP_LO_IDX        8'h0C
`define TAG_MAP_HI_IDX        8'h0D

// phy address register
`define PHY_ADDR_MSB          7
`define PHY_ADDR_LSB          3
`define PHY_ADDR_RST          5'h01
`define PHY_ADDR_MAX          5'h1D
`define PHY_RSVD_RST          3'h0

// ingress control fields
`define ING_STORM_BIT         7
`define ING_DIFFSERV_BIT      6
`define ING_DOT1P_BIT         5
`define ING_PORT_PRIO_MSB     4
`define ING_PORT_PRIO_LSB     3
`define ING_TAG_INSERT_BIT    2
`define ING_TAG_REMOVE_BIT    1
`define ING_TXQ_SPLIT_BIT     0
`define ING_RST               8'h00

// monitor control fields
`define MON_SNIFFER_BIT       7
`define MON_RX_SNIFF_BIT      6
`define MON_TX_SNIFF_BIT      5
`define MON_RST               8'h00

// 802.1p tag priority mapping reset values
`define TAG_MAP_LO_RST        8'h50
`define TAG_MAP_HI_RST        8'hFA

`endif

// [prio_classifier.v]
// per-port ingress priority resolution
// assumes classification inputs are valid in the same cycle; purely combinational
module prio_classifier (
    input  wire        diffserv_en_i,
    input  wire        dot1p_en_i,
    input  wire [1:0]  port_prio_i,
    input  wire [15:0] tag_map_i,
    input  wire        frame_tagged_i,
    input  wire [2:0]  frame_tag_prio_i,
    input  wire        frame_ipv4_i,
    input  wire [1:0]  frame_dscp_prio_i,
    output wire [1:0]  prio_o
);
    wire       dot1p_hit;
    wire       dscp_hit;
    wire [1:0] dot1p_prio;
    wire [1:0] dscp_prio;

    assign dot1p_hit  = dot1p_en_i & frame_tagged_i;
    assign dscp_hit   = diffserv_en_i & frame_ipv4_i;
    assign dot1p_prio = dot1p_hit ? tag_map_i[{frame_tag_prio_i, 1'b0} +: 2] : 2'h0;
    assign dscp_prio  = dscp_hit ? frame_dscp_prio_i : 2'h0;
    // combined classifier result overrides the port fallback
    assign prio_o     = (dot1p_hit | dscp_hit) ? (dot1p_prio | dscp_prio) : port_prio_i;
endmodule

// [port_ctl_checker.sv]
// checker for the port control bank: avalon handshake and decoded control levels
// assumes binding onto switch_port_ingress_control_regs, one clock, async high reset
module port_ctl_checker #(
    parameter NUM_PORTS = 3
) (
    input wire                 clk_i,
    input wire                 reset_i,
    input wire [9:0]           avs_address_i,
    input wire                 avs_read_i,
    input wire                 avs_write_i,
    input wire [31:0]          avs_writedata_i,
    input wire [3:0]           avs_byteenable_i,
    input wire                 avs_waitrequest_o,
    input wire [4:0]           port1_phy_addr_o,
    input wire [4:0]           port2_phy_addr_o,
    input wire [NUM_PORTS-1:0] storm_protect_en_o,
    input wire [NUM_PORTS-1:0] diffserv_en_o,
    input wire [NUM_PORTS-1:0] dot1p_en_o,
    input wire [NUM_PORTS-1:0] tag_insert_en_o,
    input wire [NUM_PORTS-1:0] tag_remove_en_o,
    input wire [NUM_PORTS-1:0] sniffer_port_o,
    input wire [1:0]           frame_port_i,
    input wire                 frame_ipv4_i,
    input wire [1:0]           frame_dscp_prio_i,
    input wire [1:0]           frame_prio_o,
    input wire [1:0]           egress_port_i,
    input wire                 egress_was_tagged_i,
    input wire                 egress_add_tag_o,
    input wire                 egress_strip_tag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ============================================================
    // register access
    a_phy_next_addr: assert property (port2_phy_addr_o == port1_phy_addr_o + 5'h01)
        else $error("port 2 phy address is not port 1 plus one");
    a_phy_legal_range: assert property (port1_phy_addr_o >= 5'h01 && port1_phy_addr_o <= 5'h1D)
        else $error("port 1 phy address outside legal codes");
    a_one_wait_state: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered after one wait state");
    a_storm_write: assert property (avs_write_i && avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[9:2] == 8'h10
        |=> storm_protect_en_o[0] == $past(avs_writedata_i[7])) else $error("storm enable did not follow write");
    a_sniffer_write: assert property (avs_write_i && avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[9:2] == 8'h31
        |=> sniffer_port_o[2] == $past(avs_writedata_i[7])) else $error("sniffer role did not follow write");
    a_reset_clear: assert property ($fell(reset_i) |-> storm_protect_en_o == 0 && tag_insert_en_o == 0 && dot1p_en_o == 0)
        else $error("controls not clear after reset");
    // ============================================================
    // datapath decisions
    a_add_tag: assert property (egress_port_i != 2'h0 |-> egress_add_tag_o ==
        (tag_insert_en_o[egress_port_i - 2'h1] && !egress_was_tagged_i)) else $error("tag insertion decision wrong");
    a_strip_tag: assert property (egress_port_i != 2'h0 |-> egress_strip_tag_o ==
        (tag_remove_en_o[egress_port_i - 2'h1] && egress_was_tagged_i)) else $error("tag removal decision wrong");
    a_dscp_only: assert property (frame_port_i != 2'h0 && frame_ipv4_i && diffserv_en_o[frame_port_i - 2'h1]
        && !dot1p_en_o[frame_port_i - 2'h1] |-> frame_prio_o == frame_dscp_prio_i) else $error("dscp priority wrong");
    c_write_done: cover property (avs_write_i && !avs_waitrequest_o);
    c_prio_three: cover property (frame_port_i != 2'h0 && frame_prio_o == 2'h3);
    c_add_tag: cover property (egress_add_tag_o);
    c_strip_tag: cover property (egress_strip_tag_o);
endmodule

bind switch_port_ingress_control_regs port_ctl_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_waitrequest_o(avs_waitrequest_o), .port1_phy_addr_o(port1_phy_addr_o), .port2_phy_addr_o(port2_phy_addr_o),
    .storm_protect_en_o(storm_protect_en_o), .diffserv_en_o(diffserv_en_o), .dot1p_en_o(dot1p_en_o),
    .tag_insert_en_o(tag_insert_en_o), .tag_remove_en_o(tag_remove_en_o), .sniffer_port_o(sniffer_port_o),
    .frame_port_i(frame_port_i), .frame_ipv4_i(frame_ipv4_i), .frame_dscp_prio_i(frame_dscp_prio_i),
    .frame_prio_o(frame_prio_o), .egress_port_i(egress_port_i), .egress_was_tagged_i(egress_was_tagged_i),
    .egress_add_tag_o(egress_add_tag_o), .egress_strip_tag_o(egress_strip_tag_o));

// [switch_port_ingress_control_regs_tb_top.sv]
// self-checking bench for the port control bank
// assumes the avalon slave answers after one wait state and decisions are combinational
module switch_port_ingress_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, reset_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [9:0]  avs_address_i = 10'h000;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [1:0]  frame_port_i = 2'h0, frame_dscp_prio_i = 2'h0, egress_port_i = 2'h0, mon_rx_port_i = 2'h0;
    logic [1:0]  mon_tx_port_i = 2'h0;
    logic        frame_tagged_i = 1'b0, frame_ipv4_i = 1'b0, egress_was_tagged_i = 1'b0;
    logic [2:0]  frame_tag_prio_i = 3'h0;
    wire  [31:0] avs_readdata_o;
    wire  [1:0]  avs_response_o, frame_prio_o;
    wire  [4:0]  port1_phy_addr_o, port2_phy_addr_o;
    wire  [2:0]  storm_protect_en_o, diffserv_en_o, dot1p_en_o, tag_insert_en_o, tag_remove_en_o;
    wire  [2:0]  tx_queue_four_split_enable_o, sniffer_port_o, rx_monitor_o, tx_monitor_o;
    wire         avs_waitrequest_o, egress_add_tag_o, egress_strip_tag_o, mon_forward_o;
    logic [31:0] rdata;
    logic [1:0]  rsp;
    int          failures = 0, checks_done = 0;

    always #2.5 clk_i = ~clk_i;

    switch_port_ingress_control_regs #(.NUM_PORTS(3)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
        .port1_phy_addr_o(port1_phy_addr_o), .port2_phy_addr_o(port2_phy_addr_o),
        .storm_protect_en_o(storm_protect_en_o), .diffserv_en_o(diffserv_en_o), .dot1p_en_o(dot1p_en_o),
        .tag_insert_en_o(tag_insert_en_o), .tag_remove_en_o(tag_remove_en_o),
        .tx_queue_four_split_enable_o(tx_queue_four_split_enable_o), .sniffer_port_o(sniffer_port_o),
        .rx_monitor_o(rx_monitor_o), .tx_monitor_o(tx_monitor_o), .frame_port_i(frame_port_i),
        .frame_tagged_i(frame_tagged_i), .frame_tag_prio_i(frame_tag_prio_i), .frame_ipv4_i(frame_ipv4_i),
        .frame_dscp_prio_i(frame_dscp_prio_i), .frame_prio_o(frame_prio_o), .egress_port_i(egress_port_i),
        .egress_was_tagged_i(egress_was_tagged_i), .egress_add_tag_o(egress_add_tag_o),
        .egress_strip_tag_o(egress_strip_tag_o), .mon_rx_port_i(mon_rx_port_i), .mon_tx_port_i(mon_tx_port_i),
        .mon_forward_o(mon_forward_o));

    // ============================================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one avalon transfer; waitrequest and answer taken as sampled at the rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= be;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ($sampled(avs_waitrequest_o) !== 1'b0 && n < 20);
        if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
        rdata = $sampled(avs_readdata_o);
        rsp = $sampled(avs_response_o);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] idx);
        bus(1'b0, idx, 8'h00, 4'hF);
    endtask

    task automatic fr(input logic [1:0] p, input logic t, input logic [2:0] tp, input logic v4, input logic [1:0] ds,
                      input logic [1:0] exp);
        @(posedge clk_i);
        frame_port_i <= p;
        frame_tagged_i <= t;
        frame_tag_prio_i <= tp;
        frame_ipv4_i <= v4;
        frame_dscp_prio_i <= ds;
        @(negedge clk_i);
        chk("frame priority", exp, frame_prio_o);
    endtask

    // ============================================================
    // scenarios
    task automatic test_reset();
        rd(8'h0F);
        chk("phy register", 8'h08, rdata);
        chk("response", 2'b00, rsp);
        chk("port1 phy", 5'h01, port1_phy_addr_o);
        chk("port2 phy", 5'h02, port2_phy_addr_o);
        for (int p = 1; p <= 3; p++) begin
            rd(8'(p * 16));
            chk("ingress reset", 8'h00, rdata);
            rd(8'(p * 16 + 1));
            chk("monitor reset", 8'h00, rdata);
        end
        $display("test reset done");
    endtask

    task automatic test_phy();
        wr(8'h0F, 8'hE8);
        chk("port1 phy top", 5'h1D, port1_phy_addr_o);
        chk("port2 phy top", 5'h1E, port2_phy_addr_o);
        wr(8'h0F, 8'h00);
        wr(8'h0F, 8'hF0);
        wr(8'h0F, 8'hF8);
        rd(8'h0F);
        chk("phy illegal kept", 8'hE8, rdata);
        wr(8'h0F, 8'h08);
        $display("test phy done");
    endtask

    task automatic test_ctl0();
        logic [7:0] v, got;
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 2; k++) begin
                v = k ? 8'h5A : 8'hA5;
                wr(8'((p + 1) * 16), v);
                rd(8'((p + 1) * 16));
                chk("ingress readback", v, rdata);
                got = {storm_protect_en_o[p], diffserv_en_o[p], dot1p_en_o[p], 2'b00, tag_insert_en_o[p],
                       tag_remove_en_o[p], tx_queue_four_split_enable_o[p]};
                chk("ingress levels", v & 8'hE7, got);
            end
            wr(8'((p + 1) * 16), 8'h00);
        end
        $display("test ctl0 done");
    endtask

    task automatic test_prio();
        wr(8'h20, 8'h18);
        fr(2'h2, 1'b0, 3'h0, 1'b0, 2'h0, 2'h3);
        fr(2'h2, 1'b1, 3'h5, 1'b1, 2'h1, 2'h3);
        wr(8'h20, 8'h78);
        fr(2'h2, 1'b1, 3'h5, 1'b0, 2'h0, 2'h2);
        fr(2'h2, 1'b1, 3'h5, 1'b1, 2'h1, 2'h3);
        fr(2'h2, 1'b0, 3'h0, 1'b1, 2'h0, 2'h0);
        fr(2'h2, 1'b0, 3'h0, 1'b0, 2'h0, 2'h3);
        wr(8'h0C, 8'hC0);
        fr(2'h2, 1'b1, 3'h3, 1'b0, 2'h0, 2'h3);
        fr(2'h2, 1'b1, 3'h1, 1'b0, 2'h0, 2'h0);
        $display("test prio done");
    endtask

    task automatic test_egress();
        for (int m = 0; m < 2; m++) begin
            wr(8'h30, m ? 8'h02 : 8'h04);
            for (int t = 0; t < 2; t++) begin
                @(posedge clk_i);
                egress_port_i <= 2'h3;
                egress_was_tagged_i <= t[0];
                @(negedge clk_i);
                chk("add tag", (m == 0) && (t == 0), egress_add_tag_o);
                chk("strip tag", (m == 1) && (t == 1), egress_strip_tag_o);
            end
        end
        $display("test egress done");
    endtask

    task automatic test_monitor();
        wr(8'h11, 8'h40);
        wr(8'h31, 8'hA0);
        chk("sniffer", 3'b100, sniffer_port_o);
        chk("rx monitor", 3'b001, rx_monitor_o);
        chk("tx monitor", 3'b100, tx_monitor_o);
        for (int c = 0; c < 3; c++) begin
            @(posedge clk_i);
            mon_rx_port_i <= c == 0 ? 2'h1 : 2'h2;
            mon_tx_port_i <= c == 1 ? 2'h3 : 2'h1;
            @(negedge clk_i);
            chk("monitor forward", c < 2, mon_forward_o);
        end
        $display("test monitor done");
    endtask

    task automatic test_refuse();
        rd(8'hFF);
        chk("unmapped response", 2'b10, rsp);
        chk("unmapped data", 32'h0, rdata);
        bus(1'b1, 8'h10, 8'hFF, 4'hE);
        chk("byte lane off", 3'b000, storm_protect_en_o);
        $display("test refuse done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        test_reset();
        test_phy();
        test_ctl0();
        test_prio();
        test_egress();
        test_monitor();
        test_refuse();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end
endmodule
